/* hw/ulpx_defs.svh */
// offsets, field positions, codes and timing counts of the low-power exit block
`ifndef ULPX_DEFS_SVH
`define ULPX_DEFS_SVH

// =====================================
// register offsets
`define ULPX_OFF_DEV_CTRL     8'h00
`define ULPX_OFF_DEV_STATUS   8'h04
`define ULPX_OFF_PIPE_CTRL    8'h08
`define ULPX_OFF_USB2_CFG     8'h0c
`define ULPX_OFF_PHY_PWR      8'h10
`define ULPX_OFF_PORT2_SC     8'h14

// =====================================
// field positions
`define ULPX_CHG_REQ_MSB      8
`define ULPX_CHG_REQ_LSB      5
`define ULPX_REPORT_MSB       21
`define ULPX_REPORT_LSB       18
`define ULPX_PIPE_SUSP_BIT    17
`define ULPX_USB2_SUSP_BIT    6
`define ULPX_PWR_CMD_MSB      21
`define ULPX_PWR_CMD_LSB      14
`define ULPX_PORT_LS_MSB      8
`define ULPX_PORT_LS_LSB      5

// =====================================
// codes
`define ULPX_REQ_RECOVERY     4'h8
`define ULPX_LS_U0            4'h0
`define ULPX_LS_U3            4'h3
`define ULPX_LS_DISABLED      4'h4
`define ULPX_LS_RXDETECT      4'h5
`define ULPX_LS_POLLING       4'h7
`define ULPX_LS_RECOVERY      4'h8
`define ULPX_LS_RESUME        4'hf
`define ULPX_PWR_CMD_FIX1     8'h43
`define ULPX_PWR_CMD_FIX2     8'h03
`define ULPX_PWR_CMD_RESET    8'h03

// =====================================
// timing
`define ULPX_CLK_NS           50
`define ULPX_TRAIN_NS         1000
`define ULPX_RESUME_NS        2000
`define ULPX_RECOVERY_NS      500
`define ULPX_TRAIN_CYC        ((`ULPX_TRAIN_NS + `ULPX_CLK_NS - 1) / `ULPX_CLK_NS)
`define ULPX_RESUME_CYC       ((`ULPX_RESUME_NS + `ULPX_CLK_NS - 1) / `ULPX_CLK_NS)
`define ULPX_RECOVERY_CYC     ((`ULPX_RECOVERY_NS + `ULPX_CLK_NS - 1) / `ULPX_CLK_NS)

`endif

/* hw/ulpx_pkg.sv */
// types of the low-power exit block
package ulpx_pkg;

   // =====================================
   // link states
   typedef enum logic [2:0] {
      ULPX_DISCONNECTED,
      ULPX_TRAINING,
      ULPX_U0,
      ULPX_U3,
      ULPX_RESUME,
      ULPX_RECOVERY,
      ULPX_USB2
   } ulpx_state_e;

   // =====================================
   // register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } ulpx_bus_s;

   // =====================================
   // link status toward the system
   typedef struct packed {
      logic       ss_link_up;
      logic       usb2_fallback;
      logic [3:0] link_state;
   } ulpx_link_s;

endpackage : ulpx_pkg

/* hw/ulpx_exit_fixup.sv */
// superspeed link low-power exit behaviour with phy suspend fallback
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "ulpx_defs.svh"

module ulpx_exit_fixup (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire ulpx_pkg::ulpx_bus_s bus,
   output logic [31:0]             rdata,
   input  wire logic               attach,
   input  wire logic               host_u3_req,
   input  wire logic               host_u0_req,
   output ulpx_pkg::ulpx_link_s    link
);

   localparam logic [7:0] TRAIN_CYC    = 8'(`ULPX_TRAIN_CYC);
   localparam logic [7:0] RESUME_CYC   = 8'(`ULPX_RESUME_CYC);
   localparam logic [7:0] RECOVERY_CYC = 8'(`ULPX_RECOVERY_CYC);

   // =====================================
   // registers
   ulpx_pkg::ulpx_state_e state_reg;
   ulpx_pkg::ulpx_state_e state_next;
   logic [7:0]            cnt_reg;
   logic [7:0]            cnt_next;
   logic [3:0]            chg_req_reg;
   logic                  pipe_susp_reg;
   logic                  usb2_susp_reg;
   logic [7:0]            pwr_cmd_reg;
   logic [3:0]            report_reg;
   logic                  fix_half_reg;
   logic                  fix_done_reg;
   logic [31:0]           rdata_reg;

   // =====================================
   // decode
   wire wr_ctrl  = bus.wr && (bus.addr == `ULPX_OFF_DEV_CTRL);
   wire wr_pipe  = bus.wr && (bus.addr == `ULPX_OFF_PIPE_CTRL);
   wire wr_usb2  = bus.wr && (bus.addr == `ULPX_OFF_USB2_CFG);
   wire wr_pwr   = bus.wr && (bus.addr == `ULPX_OFF_PHY_PWR);
   wire [3:0] wr_req = bus.wdata[`ULPX_CHG_REQ_MSB:`ULPX_CHG_REQ_LSB];
   wire [7:0] wr_cmd = bus.wdata[`ULPX_PWR_CMD_MSB:`ULPX_PWR_CMD_LSB];
   wire susp_both   = pipe_susp_reg && usb2_susp_reg;
   wire exit_req    = (wr_ctrl && wr_req == `ULPX_REQ_RECOVERY) || host_u0_req;
   wire in_resume   = (state_reg == ulpx_pkg::ULPX_RESUME);
   wire cnt_done    = (cnt_reg == 8'h00);

   function automatic logic [3:0] ls_code(input ulpx_pkg::ulpx_state_e s);
      unique case (s)
         ulpx_pkg::ULPX_DISCONNECTED: ls_code = `ULPX_LS_RXDETECT;
         ulpx_pkg::ULPX_TRAINING:     ls_code = `ULPX_LS_POLLING;
         ulpx_pkg::ULPX_U0:           ls_code = `ULPX_LS_U0;
         ulpx_pkg::ULPX_U3:           ls_code = `ULPX_LS_U3;
         ulpx_pkg::ULPX_RESUME:       ls_code = `ULPX_LS_RESUME;
         ulpx_pkg::ULPX_RECOVERY:     ls_code = `ULPX_LS_RECOVERY;
         ulpx_pkg::ULPX_USB2:         ls_code = `ULPX_LS_DISABLED;
      endcase
   endfunction : ls_code

   // =====================================
   // link state machine
   always_comb begin
      state_next = state_reg;
      cnt_next   = cnt_done ? 8'h00 : cnt_reg - 8'h01;
      unique case (state_reg)
         ulpx_pkg::ULPX_DISCONNECTED: begin
            if (attach) begin
               state_next = ulpx_pkg::ULPX_TRAINING;
               cnt_next   = TRAIN_CYC;
            end
         end
         ulpx_pkg::ULPX_TRAINING: begin
            // suspended phy starves training until it times out
            if (cnt_done)
               state_next = susp_both ? ulpx_pkg::ULPX_USB2 : ulpx_pkg::ULPX_U0;
         end
         ulpx_pkg::ULPX_U0: begin
            if (host_u3_req)
               state_next = ulpx_pkg::ULPX_U3;
         end
         ulpx_pkg::ULPX_U3: begin
            if (exit_req) begin
               state_next = ulpx_pkg::ULPX_RESUME;
               cnt_next   = RESUME_CYC;
            end
         end
         ulpx_pkg::ULPX_RESUME: begin
            if (cnt_done) begin
               state_next = ulpx_pkg::ULPX_RECOVERY;
               cnt_next   = RECOVERY_CYC;
            end
         end
         ulpx_pkg::ULPX_RECOVERY: begin
            // with both phy suspends set and no power command pair the link falls back to USB2
            if (susp_both && !fix_done_reg)
               state_next = ulpx_pkg::ULPX_USB2;
            else if (cnt_done)
               state_next = ulpx_pkg::ULPX_U0;
         end
         ulpx_pkg::ULPX_USB2: begin
            state_next = ulpx_pkg::ULPX_USB2;
         end
      endcase
      if (!attach)
         state_next = ulpx_pkg::ULPX_DISCONNECTED;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= ulpx_pkg::ULPX_DISCONNECTED;
         cnt_reg    <= 8'h00;
         report_reg <= `ULPX_LS_RXDETECT;
      end else begin
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         report_reg <= ls_code(state_next);
      end
   end

   // =====================================
   // fix-up tracking, cleared at each U3 entry
   wire fix_clr  = (state_next == ulpx_pkg::ULPX_U3) && (state_reg != ulpx_pkg::ULPX_U3);
   wire fix1_set = wr_pwr && in_resume && (wr_cmd == `ULPX_PWR_CMD_FIX1);
   wire fix2_set = wr_pwr && in_resume && fix_half_reg && (wr_cmd == `ULPX_PWR_CMD_FIX2);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fix_half_reg <= 1'b0;
         fix_done_reg <= 1'b0;
      end else begin
         fix_half_reg <= fix1_set | (fix_half_reg & ~fix_clr);
         fix_done_reg <= fix2_set | (fix_done_reg & ~fix_clr);
      end
   end

   // =====================================
   // software registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chg_req_reg   <= 4'h0;
         pipe_susp_reg <= 1'b0;
         usb2_susp_reg <= 1'b0;
         pwr_cmd_reg   <= `ULPX_PWR_CMD_RESET;
      end else begin
         if (wr_ctrl) chg_req_reg <= wr_req;
         if (wr_pipe) pipe_susp_reg <= bus.wdata[`ULPX_PIPE_SUSP_BIT];
         if (wr_usb2) usb2_susp_reg <= bus.wdata[`ULPX_USB2_SUSP_BIT];
         if (wr_pwr) pwr_cmd_reg <= wr_cmd;
      end
   end

   // =====================================
   // read port, data one cycle after the strobe
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (bus.addr)
         `ULPX_OFF_DEV_CTRL:   rd_mux[`ULPX_CHG_REQ_MSB:`ULPX_CHG_REQ_LSB] = chg_req_reg;
         `ULPX_OFF_DEV_STATUS: rd_mux[`ULPX_REPORT_MSB:`ULPX_REPORT_LSB] = report_reg;
         `ULPX_OFF_PIPE_CTRL:  rd_mux[`ULPX_PIPE_SUSP_BIT] = pipe_susp_reg;
         `ULPX_OFF_USB2_CFG:   rd_mux[`ULPX_USB2_SUSP_BIT] = usb2_susp_reg;
         `ULPX_OFF_PHY_PWR:    rd_mux[`ULPX_PWR_CMD_MSB:`ULPX_PWR_CMD_LSB] = pwr_cmd_reg;
         `ULPX_OFF_PORT2_SC:   rd_mux[`ULPX_PORT_LS_MSB:`ULPX_PORT_LS_LSB] = report_reg;
         default:              rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rdata_reg <= 32'h0000_0000;
      else
         rdata_reg <= bus.rd ? rd_mux : 32'h0000_0000;
   end

   assign rdata              = rdata_reg;
   wire ss_up_w    = (state_reg == ulpx_pkg::ULPX_U0);
   wire fallback_w = (state_reg == ulpx_pkg::ULPX_USB2);
   assign link     = '{ss_link_up: ss_up_w, usb2_fallback: fallback_w, link_state: report_reg};

   // =====================================
   // checks
   a_leave_u3_request: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == ulpx_pkg::ULPX_U3) && attach && wr_ctrl && (wr_req == `ULPX_REQ_RECOVERY)
      |=> in_resume && (cnt_reg == RESUME_CYC))
      else $error("recovery request did not leave U3");

   a_resume_report: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(in_resume) |-> (link.link_state == 4'hf) [*3])
      else $error("reset/resume code not reported on Deep_sleep_exit_point");

   a_attach_fallback: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == ulpx_pkg::ULPX_TRAINING) && cnt_done && susp_both && attach
      |=> link.usb2_fallback && !link.ss_link_up)
      else $error("suspended attach did not fall back to usb2");

   a_attach_ss_up: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == ulpx_pkg::ULPX_TRAINING) && cnt_done && !susp_both && attach |=> link.ss_link_up)
      else $error("training without suspend did not reach U0");

   a_exit_no_fix: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_reg == ulpx_pkg::ULPX_RECOVERY) && susp_both && !fix_done_reg && attach
      |=> link.usb2_fallback)
      else $error("unfixed Deep_sleep_exit_point kept the superspeed link");

   a_exit_fixed: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_reg == ulpx_pkg::ULPX_RECOVERY) && fix_done_reg
      |-> ##[1:12] (link.ss_link_up || !attach))
      else $error("fixed Deep_sleep_exit_point did not return to U0");

   a_fix_rearm: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state_reg == ulpx_pkg::ULPX_U3) |-> !fix_done_reg && !fix_half_reg)
      else $error("fix-up tracking not cleared at U3 entry");

   c_ss_up:       cover property (@(posedge clk) disable iff (!rst_n) $rose(link.ss_link_up));
   c_fix_resumed: cover property (@(posedge clk) disable iff (!rst_n)
      fix_done_reg && $rose(state_reg == ulpx_pkg::ULPX_RECOVERY));
   c_fallback:    cover property (@(posedge clk) disable iff (!rst_n) $rose(link.usb2_fallback));

endmodule : ulpx_exit_fixup

/* tb/ulpx_partner.sv */
// attached superspeed device and host request source for the exit bench
`timescale 1ns/1ps

module ulpx_partner (
   input  wire logic clk,
   output logic      attach,
   output logic      host_u3_req,
   output logic      host_u0_req
);
   initial begin
      attach = 1'b0;
      host_u3_req = 1'b0;
      host_u0_req = 1'b0;
   end

   // =====================================
   // plug level, changed right after an edge
   task plug(input logic v);
      @(posedge clk);
      attach <= v;
   endtask : plug

   // one-cycle host request: 1 asks exit, 0 asks entry
   task ask(input logic exit_req);
      @(posedge clk);
      if (exit_req) begin
         host_u0_req <= 1'b1;
      end else begin
         host_u3_req <= 1'b1;
      end
      @(posedge clk);
      host_u0_req <= 1'b0;
      host_u3_req <= 1'b0;
      #1;
   endtask : ask
endmodule : ulpx_partner

/* tb/ulpx_exit_fixup_test.sv */
// self-checking bench of the low-power exit block
`timescale 1ns/1ps

module ulpx_exit_fixup_test;
   logic                 clk;
   logic                 rst_n;
   ulpx_pkg::ulpx_bus_s  bus;
   logic [31:0]          rdata;
   logic [31:0]          d;
   logic                 attach;
   logic                 u3;
   logic                 u0;
   ulpx_pkg::ulpx_link_s link;
   int                   failures;
   int                   checks;
   logic [7:0]           ra[5] = '{8'h00, 8'h08, 8'h0c, 8'h10, 8'h20};
   logic [31:0]          rv[5] = '{32'h0, 32'h0, 32'h0, 32'h0000c000, 32'h0};

   ulpx_exit_fixup ulpx_exit_fixup_inst (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .attach(attach), .host_u3_req(u3), .host_u0_req(u0), .link(link));
   ulpx_partner ulpx_partner_inst (.clk(clk), .attach(attach), .host_u3_req(u3), .host_u0_req(u0));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // =====================================
   // helpers
   task end_sim;
      $display("failures %0d checks %0d", failures, checks);
      if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   // one access; read data land in d
   task acc(input logic [7:0] a, input logic wr_en, input logic [31:0] wd);
      @(posedge clk);
      bus <= '{addr: a, wdata: wd, wr: wr_en, rd: !wr_en};
      @(posedge clk);
      bus <= '0;
      #1 d = rdata;
   endtask : acc

   // wait on the flags only, so a transient F code is never taken as a state
   task settle(input int n);
      for (int i = 0; i < n && link.ss_link_up !== 1'b1 && link.usb2_fallback !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
   endtask : settle

   // u3 entry, exit by host or by register, optional power command pair
   task exit_u3(input logic by_host, input logic fix, input logic exp_up);
      ulpx_partner_inst.ask(1'b0);
      chk("link_state u3", 32'(link.link_state), 32'h3);
      if (by_host) ulpx_partner_inst.ask(1'b1);
      else acc(8'h00, 1'b1, 32'h00000100);
      d = '0;
      for (int i = 0; i < 6 && d[8:5] !== 4'hf; i++) acc(8'h14, 1'b0, 32'h0);
      chk("port2 state", 32'(d[8:5]), 32'hf);
      acc(8'h04, 1'b0, 32'h0);
      chk("status report", 32'(d[21:18]), 32'hf);
      if (fix) begin
         acc(8'h10, 1'b1, {10'h0, 8'h43, 14'h0});
         acc(8'h10, 1'b1, {10'h0, 8'h03, 14'h0});
      end
      settle(80);
      chk("ss_link_up", 32'(link.ss_link_up), 32'(exp_up));
      chk("usb2_fallback", 32'(link.usb2_fallback), 32'(!exp_up));
   endtask : exit_u3

   // =====================================
   // tests
   initial begin
      bus = '0;
      d = '0;
      failures = 0;
      checks = 0;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      acc(8'h20, 1'b1, 32'hffffffff);
      foreach (ra[i]) begin
         acc(ra[i], 1'b0, 32'h0);
         chk("reset read", d, rv[i]);
      end
      chk("link_state reset", 32'(link.link_state), 32'h5);
      ulpx_partner_inst.plug(1'b1);
      settle(30);
      chk("ss_link_up train", 32'(link.ss_link_up), 32'h1);
      chk("link_state u0", 32'(link.link_state), 32'h0);
      exit_u3(1'b0, 1'b0, 1'b1);
      acc(8'h08, 1'b1, 32'h00020000);
      acc(8'h0c, 1'b1, 32'h00000040);
      acc(8'h08, 1'b0, 32'h0);
      chk("pipe suspend", d, 32'h00020000);
      acc(8'h0c, 1'b0, 32'h0);
      chk("usb2 suspend", d, 32'h00000040);
      exit_u3(1'b1, 1'b1, 1'b1);
      exit_u3(1'b0, 1'b1, 1'b1);
      exit_u3(1'b1, 1'b0, 1'b0);
      chk("link_state fallback", 32'(link.link_state), 32'h4);
      ulpx_partner_inst.plug(1'b0);
      repeat (3) @(posedge clk);
      ulpx_partner_inst.plug(1'b1);
      #100;
      settle(30);
      chk("attach fallback", 32'(link.usb2_fallback), 32'h1);
      end_sim;
   end

   initial begin
      #(50 * 4000);
      failures++;
      end_sim;
   end
endmodule : ulpx_exit_fixup_test
